/* File: inc/lgpm_cfg.svh */
// Offsets, fixed pages, reset values and window bounds of the page mapper
`ifndef LGPM_CFG_SVH
`define LGPM_CFG_SVH

// ****************************************
// Register offsets in the register space
// ****************************************
`define LGPM_GLB_PAGE_OFS 11'h010
`define LGPM_PRG_PAGE_OFS 11'h015
`define LGPM_RAM_PAGE_OFS 11'h016
`define LGPM_DFL_PAGE_OFS 11'h017
`define LGPM_DBG_PAGE_OFS 11'h01F

// ****************************************
// Reset values
// ****************************************
`define LGPM_RAM_PAGE_RST 8'hFD
`define LGPM_PRG_PAGE_RST 8'hFE
`define LGPM_DFL_PAGE_RST 8'h00
`define LGPM_GLB_PAGE_RST 7'h00
`define LGPM_DBG_PAGE_RST 7'h00

// ****************************************
// Local windows and fixed pages
// ****************************************
`define LGPM_REG_TOP 16'h07FF
`define LGPM_DFL_WIN_LO 16'h0800
`define LGPM_DFL_WIN_HI 16'h0BFF
`define LGPM_DFL_FIX_HI 16'h0FFF
`define LGPM_RAM_WIN_LO 16'h1000
`define LGPM_RAM_WIN_HI 16'h1FFF
`define LGPM_RAM_FIXA_HI 16'h2FFF
`define LGPM_RAM_FIXB_HI 16'h3FFF
`define LGPM_PRG_FIXA_HI 16'h7FFF
`define LGPM_PRG_WIN_HI 16'hBFFF
`define LGPM_DBG_ALT_LO 16'hBF00
`define LGPM_DBG_WIN_LO 16'hFF00
`define LGPM_DFL_FIX_PAGE 8'hFF
`define LGPM_RAM_FIXA_PAGE 8'hFE
`define LGPM_RAM_FIXB_PAGE 8'hFF
`define LGPM_PRG_FIXA_PAGE 8'hFD
`define LGPM_PRG_FIX_PAGE 8'hFF

// ****************************************
// Global map layout
// ****************************************
`define LGPM_REG_GLB_TOP 23'h0007FF
`define LGPM_RAM_GLB_TOP 23'h0FFFFF
`define LGPM_DFL_GLB_TOP 23'h13FFFF
`define LGPM_DFL_GLB_TAG 5'h04
`define LGPM_PRG_GLB_LO 23'h400000
`define LGPM_STRAP_WAIT 3'h5

`endif

/* File: inc/lgpm_pkg.sv */
// Types shared by the page mapper files
package lgpm_pkg;

  // One-hot target selection on the memory side
  typedef enum logic [5:0] {
    LGPM_TGT_NONE = 6'h01,
    LGPM_TGT_REGS = 6'h02,
    LGPM_TGT_RAM = 6'h04,
    LGPM_TGT_DFL = 6'h08,
    LGPM_TGT_PRG = 6'h10,
    LGPM_TGT_DBG = 6'h20
  } lgpm_tgt_t;

endpackage : lgpm_pkg

/* File: hdl/lgpm_page_reg.sv */
// One page index register with its own reset value
`timescale 1ns/1ns
`default_nettype none

module lgpm_page_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic wrEn, // Write strobe
  input wire logic [W-1:0] wrData, // Value to store
  output logic [W-1:0] pageQ // Current page value
);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pageQ <= RST;
    end else if (wrEn) begin
      pageQ <= wrData;
    end
  end

endmodule : lgpm_page_reg

`default_nettype wire

/* File: hdl/lgpm_mapper.sv */
// Local to global page mapper for core and debug masters
`timescale 1ns/1ns
`default_nettype none
`include "lgpm_cfg.svh"

module lgpm_mapper (
  input wire logic clk, // System clock, 10 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic cpuValid, // Core access request
  input wire logic cpuWrite, // Core access is a write
  input wire logic [15:0] cpuAddr, // Core local address
  input wire logic [7:0] cpuWdata, // Core write data
  input wire logic cpuGlobal, // Core executes a global instruction
  input wire logic cpuFirmware, // Core executes a debug firmware command
  input wire logic debugSpaceReadCycle, // Dedicated debug space read cycle
  input wire logic debugSpaceWriteCycle, // Dedicated debug space write cycle
  input wire logic callPageWr, // Call/return special program page write
  input wire logic [7:0] callPageData, // Page value from call/return
  input wire logic dbgValid, // Debug unit hardware command access
  input wire logic dbgWrite, // Debug access is a write
  input wire logic [15:0] dbgAddr, // Debug unit local address
  input wire logic [7:0] dbgWdata, // Debug write data
  input wire logic dbgGlobal, // Hardware word or byte command, global form
  input wire logic debugEnter, // Enter active debug
  input wire logic debugExit, // Leave active debug
  input wire logic specialModePin, // Special single-chip strap pin
  output logic accValid_r, // Target access valid
  output logic accWrite_r, // Target access is a write
  output logic [22:0] glbAddr_r, // Global address
  output logic [7:0] accWdata_r, // Target write data
  output lgpm_pkg::lgpm_tgt_t accTarget_r, // Selected target
  output logic accFromDbg_r, // Access belongs to the debug unit
  output logic [7:0] regRdata_r, // Page register read data
  output logic regRvalid_r, // Page register read data valid
  output logic [7:0] programPage_r, // Program page for call stacking
  output logic activeDebug_r, // Active debug mode
  output logic extBusEn_r // External bus enable, never set
);
  import lgpm_pkg::*;

  // ****************************************
  // Page registers
  // ****************************************
  logic [7:0] ramPageIndex;
  logic [7:0] dataFlashPageIndex;
  logic [7:0] programPageIndex;
  logic [6:0] globalPageIndex;
  logic [6:0] debugGlobalPageIndex;
  logic ramWr;
  logic dflWr;
  logic prgWr;
  logic glbWr;
  logic dbgpWr;
  logic [7:0] prgWrData;
  logic [7:0] selWdata;

  lgpm_page_reg #(.W(8), .RST(`LGPM_RAM_PAGE_RST)) uRamPage (
    .clk(clk),
    .nrst(nrst),
    .wrEn(ramWr),
    .wrData(selWdata),
    .pageQ(ramPageIndex)
  );

  lgpm_page_reg #(.W(8), .RST(`LGPM_DFL_PAGE_RST)) uDflPage (
    .clk(clk),
    .nrst(nrst),
    .wrEn(dflWr),
    .wrData(selWdata),
    .pageQ(dataFlashPageIndex)
  );

  lgpm_page_reg #(.W(8), .RST(`LGPM_PRG_PAGE_RST)) uPrgPage (
    .clk(clk),
    .nrst(nrst),
    .wrEn(prgWr),
    .wrData(prgWrData),
    .pageQ(programPageIndex)
  );

  lgpm_page_reg #(.W(7), .RST(`LGPM_GLB_PAGE_RST)) uGlbPage (
    .clk(clk),
    .nrst(nrst),
    .wrEn(glbWr),
    .wrData(selWdata[6:0]),
    .pageQ(globalPageIndex)
  );

  lgpm_page_reg #(.W(7), .RST(`LGPM_DBG_PAGE_RST)) uDbgPage (
    .clk(clk),
    .nrst(nrst),
    .wrEn(dbgpWr),
    .wrData(selWdata[6:0]),
    .pageQ(debugGlobalPageIndex)
  );

  // ****************************************
  // Master selection
  // ****************************************
  // Core wins; a debug request in a core cycle is dropped, and nothing stalls the debug unit
  logic selValid;
  logic selDbg;
  logic selWrite;
  logic [15:0] selAddr;
  logic selGlobal;
  logic [6:0] selGlbPage;

  always_comb begin
    selDbg = !cpuValid && dbgValid;
    selValid = cpuValid || dbgValid;
    selWrite = selDbg ? dbgWrite : cpuWrite;
    selAddr = selDbg ? dbgAddr : cpuAddr;
    selWdata = selDbg ? dbgWdata : cpuWdata;
    if (selDbg) begin
      selGlobal = dbgGlobal;
      selGlbPage = debugGlobalPageIndex;
    end else if (cpuFirmware) begin
      selGlobal = cpuGlobal;
      selGlbPage = debugGlobalPageIndex;
    end else begin
      selGlobal = cpuGlobal;
      selGlbPage = globalPageIndex;
    end
  end

  // ****************************************
  // Local map expansion
  // ****************************************
  // Same expansion for both masters
  function automatic logic [22:0] expandLocal(
    input logic [15:0] a,
    input logic [7:0] rp,
    input logic [7:0] ep,
    input logic [7:0] pp
  );
    logic [22:0] g;
    g = '0;
    if (a <= `LGPM_REG_TOP) begin
      g = {7'h00, a};
    end else if (a <= `LGPM_DFL_WIN_HI) begin
      g = {`LGPM_DFL_GLB_TAG, ep, a[9:0]};
    end else if (a <= `LGPM_DFL_FIX_HI) begin
      g = {`LGPM_DFL_GLB_TAG, `LGPM_DFL_FIX_PAGE, a[9:0]};
    end else if (a <= `LGPM_RAM_WIN_HI) begin
      g = {3'h0, rp, a[11:0]};
    end else if (a <= `LGPM_RAM_FIXA_HI) begin
      g = {3'h0, `LGPM_RAM_FIXA_PAGE, a[11:0]};
    end else if (a <= `LGPM_RAM_FIXB_HI) begin
      g = {3'h0, `LGPM_RAM_FIXB_PAGE, a[11:0]};
    end else if (a <= `LGPM_PRG_FIXA_HI) begin
      g = {1'b1, `LGPM_PRG_FIXA_PAGE, a[13:0]};
    end else if (a <= `LGPM_PRG_WIN_HI) begin
      g = {1'b1, pp, a[13:0]};
    end else begin
      g = {1'b1, `LGPM_PRG_FIX_PAGE, a[13:0]};
    end
    return g;
  endfunction : expandLocal

  logic [22:0] mapAddr;
  logic inDbgWin;
  logic dbgCycle;
  lgpm_tgt_t mapTgt;

  always_comb begin
    // Page registers read directly, no wait
    if (selGlobal) begin
      mapAddr = {selGlbPage, selAddr};
    end else begin
      mapAddr = expandLocal(selAddr, ramPageIndex, dataFlashPageIndex, programPageIndex);
    end
    // Alternate window with program page 0xFF
    inDbgWin = activeDebug_r && !selGlobal &&
      ((selAddr >= `LGPM_DBG_WIN_LO) ||
       (selAddr >= `LGPM_DBG_ALT_LO && selAddr <= `LGPM_PRG_WIN_HI &&
        programPageIndex == `LGPM_PRG_FIX_PAGE));
    dbgCycle = !selDbg && (debugSpaceReadCycle || debugSpaceWriteCycle);
    // Debug space only in its own cycles
    if (inDbgWin) begin
      mapTgt = dbgCycle ? LGPM_TGT_DBG : LGPM_TGT_NONE;
    end else if (mapAddr <= `LGPM_REG_GLB_TOP) begin
      mapTgt = LGPM_TGT_REGS;
    end else if (mapAddr <= `LGPM_RAM_GLB_TOP) begin
      mapTgt = LGPM_TGT_RAM;
    end else if (mapAddr <= `LGPM_DFL_GLB_TOP) begin
      mapTgt = LGPM_TGT_DFL;
    end else if (mapAddr >= `LGPM_PRG_GLB_LO) begin
      mapTgt = LGPM_TGT_PRG;
    end else begin
      mapTgt = LGPM_TGT_NONE;
    end
  end

  // ****************************************
  // Register space decode
  // ****************************************
  logic regHit;
  logic regWr;
  logic [7:0] regRd;

  always_comb begin
    regHit = selValid && mapTgt == LGPM_TGT_REGS;
    regWr = regHit && selWrite;
    ramWr = regWr && mapAddr[10:0] == `LGPM_RAM_PAGE_OFS;
    dflWr = regWr && mapAddr[10:0] == `LGPM_DFL_PAGE_OFS;
    glbWr = regWr && mapAddr[10:0] == `LGPM_GLB_PAGE_OFS;
    dbgpWr = regWr && mapAddr[10:0] == `LGPM_DBG_PAGE_OFS;
    // Call/return path takes precedence over a memory write
    prgWr = callPageWr || (regWr && mapAddr[10:0] == `LGPM_PRG_PAGE_OFS);
    prgWrData = callPageWr ? callPageData : selWdata;
    unique case (mapAddr[10:0])
      `LGPM_RAM_PAGE_OFS: regRd = ramPageIndex;
      `LGPM_DFL_PAGE_OFS: regRd = dataFlashPageIndex;
      `LGPM_PRG_PAGE_OFS: regRd = programPageIndex;
      `LGPM_GLB_PAGE_OFS: regRd = {1'b0, globalPageIndex};
      `LGPM_DBG_PAGE_OFS: regRd = {1'b0, debugGlobalPageIndex};
      default: regRd = 8'h00;
    endcase
  end

  // ****************************************
  // Target side outputs
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      accValid_r <= 1'b0;
      accWrite_r <= 1'b0;
      glbAddr_r <= 23'h000000;
      accWdata_r <= 8'h00;
      accTarget_r <= LGPM_TGT_NONE;
      accFromDbg_r <= 1'b0;
    end else begin
      accValid_r <= selValid;
      accWrite_r <= selValid && selWrite;
      glbAddr_r <= mapAddr;
      accWdata_r <= selWdata;
      accTarget_r <= selValid ? mapTgt : LGPM_TGT_NONE;
      accFromDbg_r <= selDbg;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata_r <= 8'h00;
      regRvalid_r <= 1'b0;
      programPage_r <= `LGPM_PRG_PAGE_RST;
    end else begin
      regRdata_r <= regHit && !selWrite ? regRd : 8'h00;
      regRvalid_r <= regHit && !selWrite;
      programPage_r <= prgWr ? prgWrData : programPageIndex;
    end
  end

  // Single-chip only, external bus held off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      extBusEn_r <= 1'b0;
    end else begin
      extBusEn_r <= 1'b0;
    end
  end

  // ****************************************
  // Operating mode
  // ****************************************
  // Strap passes three stages; a level counts once stages two and three agree
  logic [2:0] strapSync_r;
  logic strapStable_r;
  // Load waits until the filtered strap has passed all three stages and settled
  logic [2:0] startCnt_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strapSync_r <= 3'h0;
      strapStable_r <= 1'b0;
    end else begin
      strapSync_r <= {strapSync_r[1:0], specialModePin};
      if (strapSync_r[1] == strapSync_r[2]) begin
        strapStable_r <= strapSync_r[2];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      startCnt_r <= 3'h0;
    end else if (startCnt_r != `LGPM_STRAP_WAIT) begin
      startCnt_r <= startCnt_r + 3'h1;
    end
  end

  // Special mode starts in active debug
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      activeDebug_r <= 1'b0;
    end else if (startCnt_r == `LGPM_STRAP_WAIT - 3'h1) begin
      activeDebug_r <= strapStable_r;
    end else if (debugEnter) begin
      activeDebug_r <= 1'b1;
    end else if (debugExit) begin
      activeDebug_r <= 1'b0;
    end
  end

endmodule : lgpm_mapper

`default_nettype wire

/* File: test/lgpm_mapper_props.sv */
// Concurrent checks on the page mapper ports
`timescale 1ns/1ns
`default_nettype none

module lgpm_mapper_props (
  input wire logic clk, // System clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic cpuValid, // Core request
  input wire logic [15:0] cpuAddr, // Core local address
  input wire logic cpuGlobal, // Global instruction
  input wire logic debugSpaceReadCycle, // Debug space read cycle
  input wire logic debugSpaceWriteCycle, // Debug space write cycle
  input wire logic callPageWr, // Call/return page write
  input wire logic [7:0] callPageData, // Call/return page value
  input wire logic dbgValid, // Debug unit request
  input wire logic [15:0] dbgAddr, // Debug unit local address
  input wire logic dbgGlobal, // Debug hardware command, global form
  input wire logic accValid_r, // Target access valid
  input wire logic [22:0] glbAddr_r, // Global address
  input wire lgpm_pkg::lgpm_tgt_t accTarget_r, // Selected target
  input wire logic accFromDbg_r, // Access from debug unit
  input wire logic [7:0] programPage_r, // Program page
  input wire logic activeDebug_r, // Active debug mode
  input wire logic extBusEn_r, // External bus enable
  input wire logic regRvalid_r // Register read valid
);
  import lgpm_pkg::*;
  // ****************************************
  // Port relations
  // ****************************************
  logic plain;
  assign plain = cpuValid && !cpuGlobal;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_ext_bus_off: assert property (!extBusEn_r)
    else $error("external bus enabled");
  a_ram_fixed_a: assert property (plain && cpuAddr[15:12] == 4'h2 |=>
    glbAddr_r == {11'h0FE, $past(cpuAddr[11:0])} && accTarget_r == LGPM_TGT_RAM)
    else $error("fixed RAM block A misplaced");
  a_ram_fixed_b: assert property (plain && cpuAddr[15:12] == 4'h3 |=>
    glbAddr_r == {11'h0FF, $past(cpuAddr[11:0])} && accTarget_r == LGPM_TGT_RAM)
    else $error("fixed RAM block B misplaced");
  a_prg_fixed: assert property (plain && cpuAddr[15:14] == 2'h3 &&
    cpuAddr[15:8] != 8'hFF |=> glbAddr_r == {9'h1FF, $past(cpuAddr[13:0])})
    else $error("fixed program block misplaced");
  a_dfl_window: assert property (plain && cpuAddr[15:10] == 6'h02 |=>
    glbAddr_r[22:18] == 5'h04 && glbAddr_r[9:0] == $past(cpuAddr[9:0]))
    else $error("data flash window misplaced");
  a_global_low: assert property (cpuValid && cpuGlobal |=>
    glbAddr_r[15:0] == $past(cpuAddr))
    else $error("global low bits wrong");
  a_dbg_low: assert property (!cpuValid && dbgValid && dbgGlobal |=>
    accFromDbg_r && glbAddr_r[15:0] == $past(dbgAddr))
    else $error("debug global low bits wrong");
  a_no_wait: assert property (accValid_r == $past(cpuValid || dbgValid))
    else $error("access not forwarded next cycle");
  a_dbg_gated: assert property (accTarget_r == LGPM_TGT_DBG |->
    $past(activeDebug_r) && $past(debugSpaceReadCycle || debugSpaceWriteCycle))
    else $error("debug space selected outside debug cycle");
  a_call_page: assert property (callPageWr |=> programPage_r == $past(callPageData))
    else $error("call page write lost");
  a_prg_reset: assert property ($rose(nrst) |-> programPage_r == 8'hFE)
    else $error("program page reset value wrong");

  c_dbg_space: cover property (accTarget_r == LGPM_TGT_DBG);
  c_reg_read: cover property (regRvalid_r);
  c_dbg_access: cover property (accValid_r && accFromDbg_r);
endmodule : lgpm_mapper_props

bind lgpm_mapper lgpm_mapper_props u_props (.clk, .nrst, .cpuValid, .cpuAddr, .cpuGlobal,
  .debugSpaceReadCycle, .debugSpaceWriteCycle, .callPageWr, .callPageData, .dbgValid,
  .dbgAddr, .dbgGlobal, .accValid_r, .glbAddr_r, .accTarget_r, .accFromDbg_r,
  .programPage_r, .activeDebug_r, .extBusEn_r, .regRvalid_r);
`default_nettype wire

/* File: test/lgpm_master_model.sv */
// Core and debug unit master model driving the mapper request ports
`timescale 1ns/1ns
`default_nettype none

module lgpm_master_model (
  input wire logic clk, // System clock
  output logic cpuValid, // Core request
  output logic cpuWrite, // Core write
  output logic [15:0] cpuAddr, // Core local address
  output logic [7:0] cpuWdata, // Core write data
  output logic cpuGlobal, // Global instruction
  output logic cpuFirmware, // Firmware command
  output logic debugSpaceReadCycle, // Debug space read cycle
  output logic debugSpaceWriteCycle, // Debug space write cycle
  output logic dbgValid, // Debug unit request
  output logic dbgWrite, // Debug unit write
  output logic [15:0] dbgAddr, // Debug unit local address
  output logic [7:0] dbgWdata, // Debug unit write data
  output logic dbgGlobal // Debug hardware command, global form
);
  // ****************************************
  // Requests, held until the taking edge
  // ****************************************
  initial begin
    {cpuValid, cpuWrite, cpuAddr, cpuWdata, cpuGlobal, cpuFirmware} = '0;
    {debugSpaceReadCycle, debugSpaceWriteCycle, dbgGlobal} = 3'h0;
    {dbgValid, dbgWrite, dbgAddr, dbgWdata} = '0;
  end
  // Idle buses toggle so a stale value is never mistaken for a request
  task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic [2:0] m);
    {cpuValid, cpuWrite, cpuAddr, cpuWdata} = {1'b1, w, a, d};
    {cpuGlobal, cpuFirmware} = m[2:1];
    {debugSpaceReadCycle, debugSpaceWriteCycle} = {m[0] & ~w, m[0] & w};
    {dbgValid, dbgAddr, dbgWdata} = {1'b0, ~dbgAddr, ~dbgWdata};
    @(posedge clk);
    #1;
  endtask : cpu
  task automatic dbg(input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic g);
    {dbgValid, dbgWrite, dbgAddr, dbgWdata, dbgGlobal} = {1'b1, w, a, d, g};
    {cpuValid, cpuAddr, cpuWdata} = {1'b0, ~cpuAddr, ~cpuWdata};
    {debugSpaceReadCycle, debugSpaceWriteCycle} = 2'h0;
    @(posedge clk);
    #1;
  endtask : dbg
  task automatic idle;
    {cpuValid, cpuAddr, dbgValid, dbgAddr} = {1'b0, ~cpuAddr, 1'b0, ~dbgAddr};
    @(posedge clk);
    #1;
  endtask : idle
endmodule : lgpm_master_model
`default_nettype wire

/* File: test/lgpm_mapper_test.sv */
// Directed test sequence for the page mapper
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) \
  begin \
    samplesChecked++; \
    if ((got) !== (exp)) begin \
      nMismatch++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module lgpm_mapper_test;
  import lgpm_pkg::*;
  localparam int DLY = 1;
  logic clk, nrst, callPageWr, debugEnter, debugExit, specialModePin;
  logic cpuValid, cpuWrite, cpuGlobal, cpuFirmware, dbgValid, dbgWrite, dbgGlobal;
  logic debugSpaceReadCycle, debugSpaceWriteCycle;
  logic [15:0] cpuAddr, dbgAddr;
  logic [7:0] cpuWdata, dbgWdata, callPageData, accWdata_r, regRdata_r, programPage_r;
  logic accValid_r, accWrite_r, accFromDbg_r, regRvalid_r, activeDebug_r, extBusEn_r;
  logic [22:0] glbAddr_r;
  lgpm_tgt_t accTarget_r;
  int nMismatch = 0;
  int samplesChecked = 0;

  lgpm_master_model mst (.clk, .cpuValid, .cpuWrite, .cpuAddr, .cpuWdata, .cpuGlobal,
    .cpuFirmware, .debugSpaceReadCycle, .debugSpaceWriteCycle, .dbgValid, .dbgWrite,
    .dbgAddr, .dbgWdata, .dbgGlobal);
  lgpm_mapper dut (.clk, .nrst, .cpuValid, .cpuWrite, .cpuAddr, .cpuWdata, .cpuGlobal,
    .cpuFirmware, .debugSpaceReadCycle, .debugSpaceWriteCycle, .callPageWr, .callPageData,
    .dbgValid, .dbgWrite, .dbgAddr, .dbgWdata, .dbgGlobal, .debugEnter, .debugExit,
    .specialModePin, .accValid_r, .accWrite_r, .glbAddr_r, .accWdata_r, .accTarget_r,
    .accFromDbg_r, .regRdata_r, .regRvalid_r, .programPage_r, .activeDebug_r, .extBusEn_r);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic expAcc(input logic [22:0] a, input lgpm_tgt_t t);
    `CHK(accValid_r, 1'b1)
    `CHK(glbAddr_r, a)
    `CHK(accTarget_r, t)
  endtask : expAcc
  task automatic expReg(input logic [7:0] d);
    `CHK(regRvalid_r, 1'b1)
    `CHK(regRdata_r, d)
  endtask : expReg
  // Side-band strobes last exactly one edge while the buses rest
  task automatic strobe(input logic cw, input logic [7:0] cv, input logic en, input logic ex);
    {callPageWr, callPageData, debugEnter, debugExit} = {cw, cv, en, ex};
    mst.idle();
    {callPageWr, debugEnter, debugExit} = 3'h0;
    mst.idle();
  endtask : strobe
  task automatic endTest(input string n);
    $display("test %s finished", n);
  endtask : endTest
  task automatic printVerdict;
    $display("checked %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : printVerdict

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (500) @(posedge clk);
    nMismatch++;
    printVerdict();
  end
  initial begin
    {nrst, callPageWr, debugEnter, debugExit, callPageData} = '0;
    specialModePin = 1'b1;
    repeat (12) @(posedge clk);
    #DLY;
    nrst = 1'b1;
    mst.cpu(1'b0, 16'h0016, 8'h00, 3'h0);
    expReg(8'hFD);
    mst.cpu(1'b0, 16'h0015, 8'h00, 3'h0);
    expReg(8'hFE);
    mst.cpu(1'b0, 16'h1234, 8'h00, 3'h0);
    expAcc(23'h0FD234, LGPM_TGT_RAM);
    mst.cpu(1'b1, 16'h0016, 8'h05, 3'h0);
    mst.cpu(1'b0, 16'h1234, 8'h00, 3'h0);
    expAcc(23'h005234, LGPM_TGT_RAM);
    mst.cpu(1'b0, 16'h2ABC, 8'h00, 3'h0);
    expAcc(23'h0FEABC, LGPM_TGT_RAM);
    mst.cpu(1'b0, 16'h3ABC, 8'h00, 3'h0);
    expAcc(23'h0FFABC, LGPM_TGT_RAM);
    endTest("ram");
    mst.cpu(1'b1, 16'h0016, 8'h00, 3'h0);
    mst.cpu(1'b1, 16'h1017, 8'h3C, 3'h0);
    expAcc(23'h000017, LGPM_TGT_REGS);
    mst.cpu(1'b0, 16'h0017, 8'h00, 3'h0);
    expReg(8'h3C);
    mst.cpu(1'b0, 16'h0800, 8'h00, 3'h0);
    expAcc(23'h10F000, LGPM_TGT_DFL);
    mst.cpu(1'b0, 16'h0BFF, 8'h00, 3'h0);
    expAcc(23'h10F3FF, LGPM_TGT_DFL);
    endTest("alias");
    mst.cpu(1'b1, 16'h0015, 8'h12, 3'h0);
    mst.cpu(1'b0, 16'hBFFF, 8'h00, 3'h0);
    expAcc(23'h44BFFF, LGPM_TGT_PRG);
    mst.cpu(1'b0, 16'hC123, 8'h00, 3'h0);
    expAcc(23'h7FC123, LGPM_TGT_PRG);
    strobe(1'b1, 8'h33, 1'b0, 1'b0);
    `CHK(programPage_r, 8'h33)
    mst.cpu(1'b0, 16'h8001, 8'h00, 3'h0);
    expAcc(23'h4CC001, LGPM_TGT_PRG);
    mst.cpu(1'b0, 16'h0015, 8'h00, 3'h0);
    expReg(8'h33);
    endTest("program");
    mst.cpu(1'b1, 16'h0010, 8'hFF, 3'h0);
    mst.cpu(1'b0, 16'h0010, 8'h00, 3'h0);
    expReg(8'h7F);
    mst.cpu(1'b0, 16'h1234, 8'h00, 3'h4);
    expAcc(23'h7F1234, LGPM_TGT_PRG);
    mst.cpu(1'b1, 16'h001F, 8'h21, 3'h0);
    mst.cpu(1'b0, 16'h0456, 8'h00, 3'h6);
    expAcc(23'h210456, LGPM_TGT_NONE);
    mst.cpu(1'b0, 16'h0456, 8'h00, 3'h4);
    expAcc(23'h7F0456, LGPM_TGT_PRG);
    mst.dbg(1'b0, 16'h0789, 8'h00, 1'b1);
    expAcc(23'h210789, LGPM_TGT_NONE);
    `CHK(accFromDbg_r, 1'b1)
    mst.dbg(1'b1, 16'h0015, 8'h44, 1'b0);
    `CHK(accWdata_r, 8'h44)
    `CHK(accWrite_r, 1'b1)
    mst.dbg(1'b0, 16'h8001, 8'h00, 1'b0);
    `CHK(accWrite_r, 1'b0)
    expAcc(23'h510001, LGPM_TGT_PRG);
    endTest("global");
    `CHK(activeDebug_r, 1'b1)
    mst.cpu(1'b0, 16'hFF10, 8'h00, 3'h1);
    expAcc(23'h7FFF10, LGPM_TGT_DBG);
    mst.cpu(1'b0, 16'hFF10, 8'h00, 3'h0);
    expAcc(23'h7FFF10, LGPM_TGT_NONE);
    mst.cpu(1'b1, 16'hFF20, 8'h5A, 3'h1);
    expAcc(23'h7FFF20, LGPM_TGT_DBG);
    `CHK(accWdata_r, 8'h5A)
    `CHK(accWrite_r, 1'b1)
    mst.dbg(1'b1, 16'h0015, 8'hFF, 1'b0);
    mst.cpu(1'b0, 16'hBF20, 8'h00, 3'h1);
    expAcc(23'h7FFF20, LGPM_TGT_DBG);
    strobe(1'b0, 8'h00, 1'b0, 1'b1);
    `CHK(activeDebug_r, 1'b0)
    mst.cpu(1'b0, 16'hFF10, 8'h00, 3'h1);
    expAcc(23'h7FFF10, LGPM_TGT_PRG);
    strobe(1'b0, 8'h00, 1'b1, 1'b0);
    `CHK(activeDebug_r, 1'b1)
    `CHK(extBusEn_r, 1'b0)
    endTest("debug");
    printVerdict();
  end
endmodule : lgpm_mapper_test
`default_nettype wire
